// File: core/ecev_top.sv
// edge capture and event unit: shared 16-bit time base, five capture/compare
// modules, event flags and the shared counter-array interrupt request.
// assumes a byte register port in the clk domain and pins synchronous to clk.
//
// Summary of operation
// - mode selector byte codes: rising 20h, falling 10h, either 30h, others listed
// - a new mode code takes effect at once, no reset needed
// - each module has high and low 8-bit time registers
// - in pulse-width mode the high byte sets the duty cycle
// - a module event sets its flag in the control/flag register, which is written as a whole byte
// - five event flags and overflow flag OR into one interrupt request
// - flags stay set when the interrupt is taken
// - enable register has counter-array enable, priority register a high-priority bit
// - each source gated by own enable: module mode bit, overflow enable
// - capture on rising, falling or either edge per mode
// - qualifying edge loads 16-bit time base, sets flag, flags interrupt
// - module interrupt only with module enable, counter-array enable and global enable (enable register bit 7) all set
// - a later capture overwrites the earlier value
// - hardware never clears flags; software clears them by writing
// - module 0 captures from port 1 bit 3
// - mode selector bits 6..0: compare, rise, fall, match, toggle, pwm, irq enable
// - one free-running 16-bit time base from high and low bytes
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps

module ecev_top (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_write,
	input  wire logic                           reg_read,
	output logic      [7:0]                     reg_rdata,
	// port 1 pins and module outputs
	input  wire logic [ecev_pkg::ECEV_PORT_W-1:0]  port1_pins,
	output logic      [ecev_pkg::ECEV_MODULES-1:0] module_out,
	// interrupt request toward the core
	output logic                                counter_array_irq,
	output logic                                counter_array_priority
);
	import ecev_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0]                   irq_enable;
		logic [7:0]                   irq_prio;
		logic [7:0]                   tb_mode;
		logic                         run;
		logic                         ovf_flag;
		logic [ECEV_MODULES-1:0]      event_flag;
		logic [15:0]                  time_base;
		logic [ECEV_MODULES-1:0][7:0] mode;
		logic [ECEV_MODULES-1:0][7:0] time_high;
		logic [ECEV_MODULES-1:0][7:0] time_low;
		logic [ECEV_MODULES-1:0]      cmp_armed;
		logic [ECEV_MODULES-1:0]      out;
		logic [ECEV_MODULES-1:0]      sync1;
		logic [ECEV_MODULES-1:0]      sync2;
		logic [ECEV_MODULES-1:0]      sample;
		logic [7:0]                   rdata;
	} ecev_state_type;

	ecev_state_type s_q;
	ecev_state_type s_d;

	// ==========================================================
	// address decode shared by reads and writes
	function automatic logic ecev_in_bank(input logic [7:0] addr, input logic [7:0] base);
		ecev_in_bank = (addr >= base) && (addr < base + 8'(ECEV_MODULES));
	endfunction

	function automatic logic [2:0] ecev_bank_index(input logic [7:0] addr,
	                                               input logic [7:0] base);
		logic [7:0] diff;
		diff = addr - base;
		ecev_bank_index = diff[2:0];
	endfunction

	// ==========================================================
	// next-state logic
	always_comb begin
		logic [2:0]              idx;
		logic [ECEV_MODULES-1:0] rise;
		logic [ECEV_MODULES-1:0] fall;
		logic [ECEV_MODULES-1:0] hit;
		logic [15:0]             tb_now;
		logic                    tb_wrap;
		logic                    low_wrap;
		idx      = 3'd0;
		rise     = '0;
		fall     = '0;
		hit      = '0;
		tb_now   = s_q.time_base;
		tb_wrap  = s_q.run && (s_q.time_base == 16'hffff);
		low_wrap = s_q.run && (s_q.time_base[7:0] == 8'hff);
		s_d      = s_q;

		// pin synchroniser; only the second stage and the sample are looked at
		s_d.sync1  = port1_pins[ECEV_PIN_LO +: ECEV_MODULES];
		s_d.sync2  = s_q.sync1;
		s_d.sample = s_q.sync2;
		rise       = s_q.sync2 & ~s_q.sample;
		fall       = ~s_q.sync2 & s_q.sample;

		// free-running time base, one count per clock while running
		if (s_q.run) begin
			s_d.time_base = s_q.time_base + 16'h0001;
		end

		// software writes; bytes of the control register are written whole,
		// so the core does read-modify-write to touch a single flag
		if (reg_write) begin
			case (reg_addr)
				ECEV_IRQ_ENABLE_OFS: begin
					s_d.irq_enable = reg_wdata;
				end
				ECEV_IRQ_PRIO_OFS: begin
					s_d.irq_prio = reg_wdata & ECEV_IP_READ_MASK;
				end
				ECEV_CTRL_FLAGS_OFS: begin
					s_d.ovf_flag   = reg_wdata[ECEV_OVF_FLAG_BIT];
					s_d.run        = reg_wdata[ECEV_RUN_BIT];
					s_d.event_flag = reg_wdata[ECEV_FLAGS_LSB +: ECEV_MODULES];
				end
				ECEV_TB_MODE_OFS: begin
					s_d.tb_mode = reg_wdata;
				end
				ECEV_TB_LOW_OFS: begin
					s_d.time_base[7:0] = reg_wdata;
				end
				ECEV_TB_HIGH_OFS: begin
					s_d.time_base[15:8] = reg_wdata;
				end
				default: begin
					if (ecev_in_bank(reg_addr, ECEV_MODE_BASE_OFS)) begin
						idx = ecev_bank_index(reg_addr, ECEV_MODE_BASE_OFS);
						s_d.mode[idx] = reg_wdata & ECEV_MODE_MASK;
					end else if (ecev_in_bank(reg_addr, ECEV_TIME_LOW_BASE)) begin
						idx = ecev_bank_index(reg_addr, ECEV_TIME_LOW_BASE);
						s_d.time_low[idx]  = reg_wdata;
						s_d.cmp_armed[idx] = 1'b0;               // no false match mid-update
					end else if (ecev_in_bank(reg_addr, ECEV_TIME_HIGH_BASE)) begin
						idx = ecev_bank_index(reg_addr, ECEV_TIME_HIGH_BASE);
						s_d.time_high[idx] = reg_wdata;
						s_d.cmp_armed[idx] = 1'b1;
					end
				end
			endcase
		end

		// overflow event; the set wins over a clearing write in the same cycle
		if (tb_wrap) begin
			s_d.ovf_flag = 1'b1;
		end

		// per-module capture, compare and pulse-width behaviour
		for (int i = 0; i < ECEV_MODULES; i++) begin
			// capture: edge selection straight from the current mode bits
			if ((rise[i] && s_q.mode[i][ECEV_M_RISE]) ||
			    (fall[i] && s_q.mode[i][ECEV_M_FALL])) begin
				s_d.time_high[i]  = tb_now[15:8];
				s_d.time_low[i]   = tb_now[7:0];
				s_d.event_flag[i] = 1'b1;
			end
			// compare: match against the armed 16-bit value
			hit[i] = s_q.run && s_q.mode[i][ECEV_M_CMP_EN] && s_q.cmp_armed[i] &&
			         !s_q.mode[i][ECEV_M_PWM] &&
			         (tb_now == {s_q.time_high[i], s_q.time_low[i]});
			if (hit[i] && s_q.mode[i][ECEV_M_MATCH]) begin
				s_d.event_flag[i] = 1'b1;
				if (s_q.mode[i][ECEV_M_TOGGLE]) begin
					s_d.out[i] = ~s_q.out[i];
				end
			end
			// pulse width: high byte reloads the low byte at each low-byte wrap,
			// so a new duty takes effect only at the period boundary
			if (s_q.mode[i][ECEV_M_CMP_EN] && s_q.mode[i][ECEV_M_PWM]) begin
				if (low_wrap) begin
					s_d.time_low[i] = s_q.time_high[i];
				end
				s_d.out[i] = (tb_now[7:0] >= s_q.time_low[i]);
			end
		end

		// read data stands for one cycle only
		s_d.rdata = ECEV_BYTE_RESET;
		if (reg_read) begin
			case (reg_addr)
				ECEV_IRQ_ENABLE_OFS: s_d.rdata = s_q.irq_enable;
				ECEV_IRQ_PRIO_OFS:   s_d.rdata = s_q.irq_prio;
				ECEV_CTRL_FLAGS_OFS: begin
					s_d.rdata = {s_q.ovf_flag, s_q.run, 1'b0, s_q.event_flag};
				end
				ECEV_TB_MODE_OFS:    s_d.rdata = s_q.tb_mode;
				ECEV_TB_LOW_OFS:     s_d.rdata = s_q.time_base[7:0];
				ECEV_TB_HIGH_OFS:    s_d.rdata = s_q.time_base[15:8];
				default: begin
					if (ecev_in_bank(reg_addr, ECEV_MODE_BASE_OFS)) begin
						s_d.rdata = s_q.mode[ecev_bank_index(reg_addr, ECEV_MODE_BASE_OFS)];
					end else if (ecev_in_bank(reg_addr, ECEV_TIME_LOW_BASE)) begin
						s_d.rdata = s_q.time_low[ecev_bank_index(reg_addr, ECEV_TIME_LOW_BASE)];
					end else if (ecev_in_bank(reg_addr, ECEV_TIME_HIGH_BASE)) begin
						s_d.rdata =
							s_q.time_high[ecev_bank_index(reg_addr, ECEV_TIME_HIGH_BASE)];
					end
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q.irq_enable <= ECEV_BYTE_RESET;
			s_q.irq_prio   <= ECEV_BYTE_RESET;
			s_q.tb_mode    <= ECEV_BYTE_RESET;
			s_q.run        <= 1'b0;
			s_q.ovf_flag   <= 1'b0;
			s_q.event_flag <= '0;
			s_q.time_base  <= ECEV_TB_RESET;
			s_q.mode       <= '0;
			s_q.time_high  <= '0;
			s_q.time_low   <= '0;
			s_q.cmp_armed  <= '1;
			s_q.out        <= '0;
			s_q.sync1      <= '0;
			s_q.sync2      <= '0;
			s_q.sample     <= '0;
			s_q.rdata      <= ECEV_BYTE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// shared interrupt request; flags are left set when it is taken
	always_comb begin
		logic [ECEV_MODULES-1:0] mod_en;
		logic                    any_src;
		mod_en  = '0;
		any_src = 1'b0;
		for (int i = 0; i < ECEV_MODULES; i++) begin
			mod_en[i] = s_q.mode[i][ECEV_M_IRQ_EN];
		end
		any_src = |(s_q.event_flag & mod_en) ||
		          (s_q.ovf_flag && s_q.tb_mode[ECEV_OVF_IRQ_EN_BIT]);
		counter_array_irq = any_src &&
		                    s_q.irq_enable[ECEV_CA_IRQ_EN_BIT] &&
		                    s_q.irq_enable[ECEV_GLOBAL_IRQ_EN_BIT];
	end

	// outputs from flops
	assign counter_array_priority = s_q.irq_prio[ECEV_CA_PRIO_BIT];
	assign reg_rdata              = s_q.rdata;
	assign module_out             = s_q.out;

endmodule

// File: shared/ecev_pkg.sv
// package for the edge capture and event unit: register offsets, field positions,
// reset values and the mode codes of a module.
// assumes an 8-bit register port with byte offsets as the register addresses.
package ecev_pkg;

	// ==========================================================
	// sizes
	localparam int unsigned ECEV_MODULES = 5;
	localparam int unsigned ECEV_PORT_W  = 8;
	localparam int unsigned ECEV_PIN_LO  = 3;          // module 0 sits on port 1 bit 3

	// ==========================================================
	// register offsets
	localparam logic [7:0] ECEV_IRQ_ENABLE_OFS   = 8'ha8;  // interrupt_enable_mask
	localparam logic [7:0] ECEV_IRQ_PRIO_OFS     = 8'hb8;  // interrupt_priority_select
	localparam logic [7:0] ECEV_CTRL_FLAGS_OFS   = 8'hd8;  // counter_control_event_flags
	localparam logic [7:0] ECEV_TB_MODE_OFS      = 8'hd9;  // time base mode
	localparam logic [7:0] ECEV_MODE_BASE_OFS    = 8'hda;  // module_mode_select 0..4
	localparam logic [7:0] ECEV_TB_LOW_OFS       = 8'he9;  // time_base_low_byte
	localparam logic [7:0] ECEV_TIME_LOW_BASE    = 8'hea;  // module_time_low 0..4
	localparam logic [7:0] ECEV_TB_HIGH_OFS      = 8'hf9;  // time_base_high_byte
	localparam logic [7:0] ECEV_TIME_HIGH_BASE   = 8'hfa;  // module_time_high 0..4

	// ==========================================================
	// reset values
	localparam logic [7:0]  ECEV_BYTE_RESET = 8'h00;
	localparam logic [15:0] ECEV_TB_RESET   = 16'h0000;

	// ==========================================================
	// interrupt_enable_mask / interrupt_priority_select fields
	localparam int unsigned ECEV_GLOBAL_IRQ_EN_BIT = 7;
	localparam int unsigned ECEV_CA_IRQ_EN_BIT     = 6;
	localparam int unsigned ECEV_CA_PRIO_BIT       = 6;
	localparam logic [7:0]  ECEV_IP_READ_MASK      = 8'h7f;  // top bit unused

	// ==========================================================
	// counter_control_event_flags fields
	localparam int unsigned ECEV_OVF_FLAG_BIT = 7;
	localparam int unsigned ECEV_RUN_BIT      = 6;
	localparam int unsigned ECEV_FLAGS_LSB    = 0;

	// time base mode field: overflow interrupt enable
	localparam int unsigned ECEV_OVF_IRQ_EN_BIT = 0;

	// ==========================================================
	// module_mode_select fields, bit 7 unused
	localparam int unsigned ECEV_M_CMP_EN   = 6;
	localparam int unsigned ECEV_M_RISE     = 5;
	localparam int unsigned ECEV_M_FALL     = 4;
	localparam int unsigned ECEV_M_MATCH    = 3;
	localparam int unsigned ECEV_M_TOGGLE   = 2;
	localparam int unsigned ECEV_M_PWM      = 1;
	localparam int unsigned ECEV_M_IRQ_EN   = 0;
	localparam logic [7:0]  ECEV_MODE_MASK  = 8'h7f;

	// ==========================================================
	// listed mode codes, interrupt bit clear (set bit 0 to enable it)
	localparam logic [7:0] ECEV_CODE_CAP_RISE = 8'h20;
	localparam logic [7:0] ECEV_CODE_CAP_FALL = 8'h10;
	localparam logic [7:0] ECEV_CODE_CAP_BOTH = 8'h30;
	localparam logic [7:0] ECEV_CODE_SW_TIMER = 8'h48;
	localparam logic [7:0] ECEV_CODE_HS_OUT   = 8'h4c;
	localparam logic [7:0] ECEV_CODE_PWM      = 8'h42;

endpackage

// File: sim/ecev_checker.sv
// checker for the edge capture unit: register port, priority and interrupt timing
// assumes it is bound to ecev_top and sees only the ports of that module
`timescale 1ns/100ps
module ecev_checker import ecev_pkg::*; (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// register port and pins
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] port1_pins,
	// interrupt side
	input wire logic       counter_array_irq,
	input wire logic       counter_array_priority
);
	logic [7:0] mode0_q;
	logic [7:0] ie_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// shadow copies of what software wrote, so checks need no internal signals
	always_ff @(posedge clk) begin
		if (rst) begin
			mode0_q <= 8'h00;
			ie_q    <= 8'h00;
		end else if (reg_write && reg_addr == ECEV_MODE_BASE_OFS) begin
			mode0_q <= reg_wdata;
		end else if (reg_write && reg_addr == ECEV_IRQ_ENABLE_OFS) begin
			ie_q    <= reg_wdata;
		end
	end
	// ==========================================================
	// assertions
	a_mode_readback: assert property (reg_read && reg_addr == ECEV_MODE_BASE_OFS |=>
		reg_rdata == (mode0_q & ECEV_MODE_MASK)) else $error("mode byte read wrong");
	a_ie_readback: assert property (reg_read && reg_addr == ECEV_IRQ_ENABLE_OFS |=>
		reg_rdata == ie_q) else $error("enable byte read wrong");
	a_prio_follows: assert property (reg_write && reg_addr == ECEV_IRQ_PRIO_OFS |=>
		counter_array_priority == $past(reg_wdata[6])) else $error("priority not written");
	a_prio_holds: assert property (!(reg_write && reg_addr == ECEV_IRQ_PRIO_OFS) |=>
		$stable(counter_array_priority)) else $error("priority moved unasked");
	a_irq_ca_gate: assert property (reg_write && reg_addr == ECEV_IRQ_ENABLE_OFS
		&& !reg_wdata[6] |=> !counter_array_irq) else $error("irq without unit enable");
	a_irq_global_gate: assert property (reg_write && reg_addr == ECEV_IRQ_ENABLE_OFS
		&& !reg_wdata[7] |=> !counter_array_irq) else $error("irq without global enable");
	a_flags_sticky: assert property (counter_array_irq && !reg_write |=>
		counter_array_irq) else $error("irq dropped without a write");
	a_capture_irq: assert property (ie_q[7:6] == 2'b11 && mode0_q[ECEV_M_RISE] &&
		mode0_q[ECEV_M_IRQ_EN] &&
		$rose(port1_pins[3]) |-> ##3 counter_array_irq) else $error("capture irq late");
	a_unmapped_zero: assert property (reg_read && reg_addr == 8'h00 |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	// main scenarios
	cover property (reg_read && reg_addr == ECEV_CTRL_FLAGS_OFS);
	cover property ($rose(counter_array_irq));
	cover property ($rose(counter_array_priority));
endmodule
bind ecev_top ecev_checker chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .port1_pins(port1_pins), .counter_array_irq(counter_array_irq),
	.counter_array_priority(counter_array_priority));

// File: sim/ecev_core_model.sv
// processor core model: single-cycle register writes and reads on the byte port
// assumes the unit answers a read exactly one cycle after the strobe
`timescale 1ns/100ps
module ecev_core_model (
	// clock
	input wire logic       clk,
	// register port toward the unit
	output logic     [7:0] reg_addr,
	output logic     [7:0] reg_wdata,
	output logic           reg_write,
	output logic           reg_read,
	input wire logic [7:0] reg_rdata
);
	// idle bus at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read  = 1'b0;
	end
	// the only path that clears flags, software owns that step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		// let the write settle before the caller looks at any output
		#1;
	endtask
	// data stands one cycle only, so it is taken inside that cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
endmodule

// File: sim/testbench.sv
// testbench for the edge capture unit: registers, captures, flags and interrupt
// assumes the core model drives the register port and the bench drives the pins
`timescale 1ns/100ps
module testbench;
	import ecev_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] pins = 8'h00;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       reg_write, reg_read, irq, prio;
	logic [4:0] mout;
	logic [15:0] tb_v;
	int         errors = 0;
	int         comparisons = 0;
	int         cycles = 0;
	always #50 clk = ~clk;
	ecev_core_model core (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	ecev_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.port1_pins(pins), .module_out(mout), .counter_array_irq(irq),
		.counter_array_priority(prio));
	function automatic logic [7:0] mode_exp(logic [7:0] c);
		return c & ECEV_MODE_MASK;
	endfunction
	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, e, g);
		end
	endtask
	task automatic rdchk(string name, logic [7:0] a, logic [7:0] e);
		logic [7:0] v;
		core.rd(a, v);
		chk(name, e, v);
	endtask
	// load a static time base, move pin 3+n, then read the captured pair
	task automatic step(int n, logic [15:0] t, logic v, logic [15:0] e);
		core.wr(ECEV_TB_LOW_OFS, t[7:0]);
		core.wr(ECEV_TB_HIGH_OFS, t[15:8]);
		@(posedge clk);
		pins[3 + n] <= v;
		repeat (5) @(posedge clk);
		rdchk("cap_lo", ECEV_TIME_LOW_BASE + 8'(n), e[7:0]);
		rdchk("cap_hi", ECEV_TIME_HIGH_BASE + 8'(n), e[15:8]);
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		logic [7:0] codes [6];
		codes = '{ECEV_CODE_CAP_RISE, ECEV_CODE_CAP_FALL, ECEV_CODE_CAP_BOTH,
			ECEV_CODE_SW_TIMER, ECEV_CODE_HS_OUT, ECEV_CODE_PWM};
		void'($urandom(32'hda07));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdchk("ie", ECEV_IRQ_ENABLE_OFS, 8'h00);
		rdchk("ip", ECEV_IRQ_PRIO_OFS, 8'h00);
		rdchk("flags", ECEV_CTRL_FLAGS_OFS, 8'h00);
		rdchk("unmapped", 8'h00, 8'h00);
		// every listed code, bit 7 set to prove it reads back clear
		for (int i = 0; i < 6; i++) begin
			core.wr(ECEV_MODE_BASE_OFS + 8'(i % 5), codes[i] | 8'h81);
			rdchk("mode", ECEV_MODE_BASE_OFS + 8'(i % 5), mode_exp(codes[i] | 8'h81));
		end
		for (int n = 0; n < 5; n++) begin
			core.wr(ECEV_MODE_BASE_OFS + 8'(n), ECEV_CODE_CAP_BOTH | 8'h01);
		end
		core.wr(ECEV_CTRL_FLAGS_OFS, 8'h00);
		core.wr(ECEV_IRQ_ENABLE_OFS, 8'hc0);
		// time base stopped, so each capture returns the value just loaded
		for (int n = 0; n < 5; n++) begin
			tb_v = 16'($urandom);
			step(n, tb_v, 1'b1, tb_v);
			chk("irq", 8'h01, {7'h00, irq});
			rdchk("flags", ECEV_CTRL_FLAGS_OFS, 8'((2 << n) - 1));
		end
		core.wr(ECEV_MODE_BASE_OFS, ECEV_CODE_CAP_FALL);
		core.wr(ECEV_CTRL_FLAGS_OFS, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		step(0, 16'h1234, 1'b0, 16'h1234);
		chk("irq", 8'h00, {7'h00, irq});
		step(0, 16'h5678, 1'b1, 16'h1234);
		step(0, 16'h9abc, 1'b0, 16'h9abc);
		rdchk("flags", ECEV_CTRL_FLAGS_OFS, 8'h01);
		core.wr(ECEV_MODE_BASE_OFS, ECEV_CODE_CAP_FALL | 8'h01);
		chk("irq", 8'h01, {7'h00, irq});
		core.wr(ECEV_IRQ_ENABLE_OFS, 8'h40);
		chk("irq", 8'h00, {7'h00, irq});
		core.wr(ECEV_IRQ_ENABLE_OFS, 8'hc0);
		core.wr(ECEV_CTRL_FLAGS_OFS, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		// overflow raises the shared request once its own enable is set
		core.wr(ECEV_TB_MODE_OFS, 8'h01);
		step(1, 16'hfffd, 1'b0, 16'hfffd);
		core.wr(ECEV_CTRL_FLAGS_OFS, 8'h40);
		repeat (8) @(posedge clk);
		rdchk("flags", ECEV_CTRL_FLAGS_OFS, 8'hc0);
		chk("irq", 8'h01, {7'h00, irq});
		core.wr(ECEV_IRQ_PRIO_OFS, 8'h40);
		chk("prio", 8'h01, {7'h00, prio});
		rdchk("ip", ECEV_IRQ_PRIO_OFS, 8'h40);
		test_done();
	end
endmodule
